// file: include/mode_ctl_consts.svh
// Purpose: constants of the wake-flag mode control block
// Assumes: 125 MHz clock, word-aligned register map
// Notes: times are held in ns, cycle counts derived from them
`ifndef MODE_CTL_CONSTS_SVH
`define MODE_CTL_CONSTS_SVH

// ==========================================================
// clock and timing
`define CLK_PERIOD_NS 8
`define UV_DET_TIME_NS 100000
`define UV_DET_CYCLES (`UV_DET_TIME_NS / `CLK_PERIOD_NS)
`define GTS_TIME_NS 20000
`define GTS_CYCLES ((`GTS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================
// register byte offsets
`define REG_SIW_OFS 8'h00
`define REG_IRQ_STAT_OFS 8'h04
`define REG_IRQ_MASK_OFS 8'h08
`define REG_STATE_OFS 8'h0C

// ==========================================================
// status information word bit positions
`define SIW_WAKE_BIT 0
`define SIW_UV_BAT_BIT 8
`define SIW_UV_CC_BIT 9
`define SIW_UV_IO_BIT 10
`define SIW_ERR_BIT 11
`define SIW_MODE_EN_BIT 13
`define SIW_MODE_STANDBY_SELECT_PIN_N_BIT 14
`define SIW_PARITY_BIT 15

// ==========================================================
// interrupt bits and reset values
`define IRQ_WAKE_BIT 0
`define IRQ_UV_BIT 1
`define IRQ_STATE_BIT 2
`define IRQ_MASK_RST 3'h0

`endif

// file: include/mode_ctl_pkg.sv
// Purpose: types of the wake-flag mode control block
// Assumes: classic wishbone with 32-bit data
// Notes: state codes are gray along receive-only-standby-go-to-sleep-sleep path
package mode_ctl_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef enum logic [2:0] {
    full_operation_state = 3'h0,
    receive_only_state = 3'h1,
    standby_state = 3'h3,
    go_to_sleep_transition = 3'h2,
    sleep_state = 3'h6
  } op_state_t;

  // index order of the undervoltage channels
  typedef enum logic [1:0] {
    uv_bat = 2'h0,
    uv_cc = 2'h1,
    uv_io = 2'h2
  } uv_chan_t;

endpackage

// file: src/uv_timer.sv
// Purpose: undervoltage detection timer with active-low flag
// Assumes: cond_i already synchronised
// Notes: restart_i drops the flag and reloads the timer
`timescale 1ns/1ns
`default_nettype none
module uv_timer
#(
  parameter int CYCLES = 12500,
  parameter int CW = 14
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cond_i,
  input wire logic restart_i,
  output logic flag_n_o
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic flag_n_ff;
  logic nxt_flag_n;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_flag_n = flag_n_ff;
    if (!cond_i || restart_i)
    begin
      // timer starts over while the condition is absent or restart_i is high
      nxt_cnt = '0;
      nxt_flag_n = 1'b1;
    end
    else if (flag_n_ff)
    begin
      if (cnt_ff == CW'(CYCLES - 1))
        nxt_flag_n = 1'b0;
      else
        nxt_cnt = cnt_ff + CW'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= '0;
      flag_n_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      flag_n_ff <= nxt_flag_n;
    end
  end

  assign flag_n_o = flag_n_ff;

endmodule // uv_timer
`default_nettype wire

// file: src/wake_flag_mode_control.sv
// Purpose: operating mode control driven by the latched wake-up flag
// Assumes: mode pins, wake and undervoltage inputs are asynchronous
// Notes: status information word is read over classic wishbone
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "mode_ctl_consts.svh"
module wake_flag_mode_control
#(
  parameter int UV_CYCLES = `UV_DET_CYCLES,
  parameter int GTS_CYCLES = `GTS_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mode_ctl_pkg::wb_req_t wb_req_i,
  output var mode_ctl_pkg::wb_rsp_t wb_rsp_o,
  input wire logic standby_select_pin_n_i,
  input wire logic enable_pin_i,
  input wire logic wake_event_i,
  input wire logic [2:0] uv_cond_i,
  input wire logic rx_bus_i,
  output logic fault_indicator_out_n_o,
  output logic receive_data_o,
  output logic receive_enable_out_o,
  output logic external_supply_inhibit_out_o,
  output logic irq_o
);
  import mode_ctl_pkg::*;

  // ==========================================================
  // input synchronisers
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic wake_prev_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // standby command and idle bus, so reset causes no mode change
      sync1_ff <= 7'h08;
      sync2_ff <= 7'h08;
      wake_prev_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {uv_cond_i, rx_bus_i, wake_event_i, enable_pin_i,
                   standby_select_pin_n_i};
      sync2_ff <= sync1_ff;
      wake_prev_ff <= sync2_ff[2];
    end
  end

  logic cmd_standby_select_pin_n;
  logic cmd_en;
  logic rx_bus;
  logic [2:0] uv_cond;
  logic wake_evt;
  assign cmd_standby_select_pin_n = sync2_ff[0];
  assign cmd_en = sync2_ff[1];
  assign rx_bus = sync2_ff[3];
  assign uv_cond = sync2_ff[6:4];
  assign wake_evt = sync2_ff[2] && !wake_prev_ff;

  // ==========================================================
  // undervoltage timers
  op_state_t state_ff;
  logic wake_flag_n_ff;
  logic wake_set;
  logic [2:0] uv_flag_n;

  assign wake_set = wake_evt && (state_ff == sleep_state ||
    state_ff == standby_state ||
    state_ff == go_to_sleep_transition);

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_uv
      uv_timer
      #(
        .CYCLES(UV_CYCLES),
        .CW($clog2(UV_CYCLES + 1))
      )
      u_timer
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(uv_cond[g]),
        .restart_i(wake_set),
        .flag_n_o(uv_flag_n[g])
      );
    end
  endgenerate

  // ==========================================================
  // operating state machine
  localparam int GW = $clog2(GTS_CYCLES + 1);
  op_state_t nxt_state;
  logic [GW-1:0] gts_cnt_ff;
  logic [GW-1:0] nxt_gts_cnt;
  logic sleep_req;
  logic sleep_ok;

  // battery or io undervoltage flag forces sleep while the wake flag is clear
  assign sleep_req = !uv_flag_n[uv_bat] || !uv_flag_n[uv_io];
  assign sleep_ok = wake_flag_n_ff && !wake_set;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_gts_cnt = '0;
    case (state_ff)
      full_operation_state, receive_only_state, standby_state:
      begin
        if (sleep_req && sleep_ok)
          nxt_state = sleep_state;
        else if (cmd_standby_select_pin_n)
          nxt_state = cmd_en ? full_operation_state : receive_only_state;
        else if (cmd_en && sleep_ok)
          nxt_state = go_to_sleep_transition;
        else
          nxt_state = standby_state;
      end
      go_to_sleep_transition:
      begin
        nxt_gts_cnt = gts_cnt_ff + GW'(1);
        if (wake_set)
          nxt_state = standby_state;
        else if (cmd_standby_select_pin_n)
          nxt_state = cmd_en ? full_operation_state : receive_only_state;
        else if (!cmd_en)
          nxt_state = standby_state;
        else if (gts_cnt_ff == GW'(GTS_CYCLES - 1) && sleep_ok)
          nxt_state = sleep_state;
      end
      sleep_state:
      begin
        // only a wake-up leaves sleep
        if (wake_set)
          nxt_state = standby_state;
      end
      default:
        nxt_state = standby_state;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= standby_state;
      gts_cnt_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      gts_cnt_ff <= nxt_gts_cnt;
    end
  end

  // ==========================================================
  // wake flag and status information word
  logic wake_bit_ff;
  logic [2:0] uv_bit_ff;
  logic nxt_wake_flag_n;
  logic nxt_wake_bit;
  logic [2:0] nxt_uv_bit;
  logic enter_full;
  logic siw_read;
  logic [15:0] siw;
  logic ack_ff;

  assign enter_full = nxt_state == full_operation_state &&
    state_ff != full_operation_state;
  assign siw_read = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we &&
    !ack_ff && wb_req_i.adr == `REG_SIW_OFS;

  always_comb
  begin
    nxt_wake_flag_n = wake_flag_n_ff;
    nxt_wake_bit = wake_bit_ff;
    nxt_uv_bit = uv_bit_ff;
    if (enter_full || siw_read)
    begin
      nxt_wake_flag_n = 1'b1;
      nxt_wake_bit = 1'b0;
      nxt_uv_bit = 3'h0;
    end
    // set wins over a clear in the same cycle
    if (wake_set)
    begin
      nxt_wake_flag_n = 1'b0;
      nxt_wake_bit = 1'b1;
    end
    nxt_uv_bit = nxt_uv_bit | ~uv_flag_n;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_flag_n_ff <= 1'b1;
      wake_bit_ff <= 1'b0;
      uv_bit_ff <= 3'h0;
    end
    else
    begin
      wake_flag_n_ff <= nxt_wake_flag_n;
      wake_bit_ff <= nxt_wake_bit;
      uv_bit_ff <= nxt_uv_bit;
    end
  end

  always_comb
  begin
    siw = 16'h0000;
    siw[`SIW_WAKE_BIT] = wake_bit_ff;
    siw[`SIW_UV_BAT_BIT] = uv_bit_ff[uv_bat];
    siw[`SIW_UV_CC_BIT] = uv_bit_ff[uv_cc];
    siw[`SIW_UV_IO_BIT] = uv_bit_ff[uv_io];
    siw[`SIW_ERR_BIT] = |uv_bit_ff;
    siw[`SIW_MODE_EN_BIT] = state_ff == full_operation_state;
    siw[`SIW_MODE_STANDBY_SELECT_PIN_N_BIT] = state_ff == full_operation_state ||
      state_ff == receive_only_state;
    siw[`SIW_PARITY_BIT] = ^siw[14:0];
  end

  // ==========================================================
  // pin outputs
  logic fault_n_ff;
  logic rxd_ff;
  logic receive_enable_out_ff;
  logic inh_ff;
  logic nxt_fault_n;
  logic nxt_rxd;
  logic nxt_receive_enable_out;
  logic nxt_inh;

  always_comb
  begin
    // fault pin reads the command, not the state
    if (cmd_standby_select_pin_n && cmd_en)
      nxt_fault_n = !(|nxt_uv_bit);
    else if (cmd_standby_select_pin_n)
      nxt_fault_n = !nxt_wake_bit;
    else
      nxt_fault_n = nxt_wake_flag_n;
    if (nxt_state == full_operation_state ||
        nxt_state == receive_only_state)
    begin
      nxt_rxd = rx_bus;
      nxt_receive_enable_out = rx_bus;
    end
    else
    begin
      nxt_rxd = nxt_wake_flag_n;
      nxt_receive_enable_out = nxt_wake_flag_n;
    end
    nxt_inh = nxt_state != sleep_state;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fault_n_ff <= 1'b1;
      rxd_ff <= 1'b1;
      receive_enable_out_ff <= 1'b1;
      inh_ff <= 1'b1;
    end
    else
    begin
      fault_n_ff <= nxt_fault_n;
      rxd_ff <= nxt_rxd;
      receive_enable_out_ff <= nxt_receive_enable_out;
      inh_ff <= nxt_inh;
    end
  end

  assign fault_indicator_out_n_o = fault_n_ff;
  assign receive_data_o = rxd_ff;
  assign receive_enable_out_o = receive_enable_out_ff;
  assign external_supply_inhibit_out_o = inh_ff;

  // ==========================================================
  // wishbone slave and interrupts
  logic nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic irq_ff;
  logic [2:0] nxt_irq_stat;
  logic [2:0] nxt_irq_mask;
  logic [2:0] irq_evt;
  logic acc;
  logic wr;

  assign acc = wb_req_i.cyc && wb_req_i.stb && !ack_ff;
  assign wr = acc && wb_req_i.we && wb_req_i.sel[0];
  assign irq_evt = {nxt_state != state_ff, (uv_flag_n == 3'h7) ? 1'b0 :
    1'b1, wake_set};

  always_comb
  begin
    nxt_ack = acc;
    nxt_dat = 32'h00000000;
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_mask = irq_mask_ff;
    if (acc && !wb_req_i.we)
    begin
      case (wb_req_i.adr)
        `REG_SIW_OFS: nxt_dat = {16'h0000, siw};
        `REG_IRQ_STAT_OFS: nxt_dat = {29'h00000000, irq_stat_ff};
        `REG_IRQ_MASK_OFS: nxt_dat = {29'h00000000, irq_mask_ff};
        `REG_STATE_OFS: nxt_dat = {29'h00000000, state_ff};
        default: nxt_dat = 32'h00000000;
      endcase
    end
    if (wr && wb_req_i.adr == `REG_IRQ_STAT_OFS)
      nxt_irq_stat = irq_stat_ff & ~wb_req_i.dat[2:0];
    if (wr && wb_req_i.adr == `REG_IRQ_MASK_OFS)
      nxt_irq_mask = wb_req_i.dat[2:0];
    nxt_irq_stat = nxt_irq_stat | irq_evt;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
      irq_stat_ff <= 3'h0;
      irq_mask_ff <= `IRQ_MASK_RST;
      irq_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
    end
  end

  assign wb_rsp_o = '{ack: ack_ff, dat: dat_ff};
  assign irq_o = irq_ff;

endmodule // wake_flag_mode_control
`default_nettype wire

// file: sim/wfmc_chk.sv
// Purpose: port checker for the mode control block
// Assumes: one clock, synchronous reset
// Notes: bound to the top module below
`timescale 1ns/1ns
`default_nettype none
module wfmc_chk
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mode_ctl_pkg::wb_req_t wb_req_i,
  input wire mode_ctl_pkg::wb_rsp_t wb_rsp_o,
  input wire logic standby_select_pin_n_i,
  input wire logic fault_indicator_out_n_o,
  input wire logic receive_data_o,
  input wire logic receive_enable_out_o,
  input wire logic external_supply_inhibit_out_o,
  input wire logic irq_o
);
  import mode_ctl_pkg::*;
  // ==========================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_take: assert property (
    (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack) |=> wb_rsp_o.ack)
    else $error("ack missing");
  a_ack_single: assert property (
    wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack too long");
  a_ack_cause: assert property (
    $rose(wb_rsp_o.ack) |-> $past(wb_req_i.stb)) else $error("ack no req");
  a_dat_idle: assert property (
    !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0) else $error("dat not 0");
  a_rx_pair: assert property (
    receive_data_o == receive_enable_out_o) else $error("rx differ");
  // sleep entry only with the wake flag clear, seen on rx enable
  a_flag_no_sleep: assert property (
    $fell(external_supply_inhibit_out_o) |-> receive_enable_out_o)
    else $error("sleep with flag");
  a_fault_flag: assert property (
    !standby_select_pin_n_i [*6] |->
    fault_indicator_out_n_o == receive_enable_out_o)
    else $error("fault vs flag");
  a_reset_vals: assert property (disable iff (1'b0)
    rst_i |=> fault_indicator_out_n_o && receive_data_o
    && external_supply_inhibit_out_o && !irq_o && !wb_rsp_o.ack)
    else $error("reset values");
  c_write: cover property (wb_rsp_o.ack && wb_req_i.we);
  c_flag: cover property ($fell(receive_enable_out_o));
  c_sleep: cover property ($fell(external_supply_inhibit_out_o));
endmodule // wfmc_chk
bind wake_flag_mode_control wfmc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .standby_select_pin_n_i(standby_select_pin_n_i),
  .fault_indicator_out_n_o(fault_indicator_out_n_o),
  .receive_data_o(receive_data_o),
  .receive_enable_out_o(receive_enable_out_o),
  .external_supply_inhibit_out_o(external_supply_inhibit_out_o),
  .irq_o(irq_o));
`default_nettype wire

// file: sim/host_model.sv
// Purpose: host driving the mode pins
// Assumes: cmd bit1 standby select, bit0 enable
// Notes: pins change only after a clock edge
`timescale 1ns/1ns
`default_nettype none
module host_model
(
  input wire logic clk_i,
  input wire logic [1:0] cmd_i,
  input wire logic wake_i,
  output logic standby_select_pin_n_o,
  output logic en_o,
  output logic wake_o
);
  // flag is cleared only by full op cmd or read
  always_ff @(posedge clk_i)
  begin
    standby_select_pin_n_o <= cmd_i[1];
    en_o <= cmd_i[0];
    wake_o <= wake_i;
  end
endmodule // host_model
`default_nettype wire

// file: sim/testbench.sv
// Purpose: self-checking bench of the mode control
// Assumes: UV 20 and GTS 10 cycles
// Notes: pins vector is fault, rxd, receive_enable_out, inhibit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mode_ctl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  logic [1:0] cmd = 2'h0;
  logic wake = 1'b0;
  logic [2:0] uv = 3'h0;
  logic rxb = 1'b1;
  logic standby_select_pin_n, en, wk, fault_n, rxd, receive_enable_out, external_supply_inhibit_out, irq;
  logic [3:0] pins;
  logic [31:0] rd;
  int err_total = 0;
  int n_checks = 0;
  assign pins = {fault_n, rxd, receive_enable_out, external_supply_inhibit_out};
  always #4 clk_i = ~clk_i;
  host_model hm (.clk_i(clk_i), .cmd_i(cmd), .wake_i(wake),
    .standby_select_pin_n_o(standby_select_pin_n), .en_o(en), .wake_o(wk));
  wake_flag_mode_control #(.UV_CYCLES(20), .GTS_CYCLES(10)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .standby_select_pin_n_i(standby_select_pin_n), .enable_pin_i(en),
    .wake_event_i(wk), .uv_cond_i(uv), .rx_bus_i(rxb),
    .fault_indicator_out_n_o(fault_n), .receive_data_o(rxd),
    .receive_enable_out_o(receive_enable_out),
    .external_supply_inhibit_out_o(external_supply_inhibit_out), .irq_o(irq));
  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // holds the request until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    req <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:4'hF, dat:d};
    // no wait count assumed: only the watchdog ends a hung access
    do
    begin
      @(posedge clk_i);
    end
    while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wk_pulse;
    wake <= 1'b1;
    step(2);
    wake <= 1'b0;
    step(8);
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // tests
  initial
  begin
    step(4);
    rst_i <= 1'b0;
    step(4);
    rdc(8'h00, 32'h0);
    rdc(8'h0C, 32'h3);
    chk(pins, 4'hF);
    wb(1'b1, 8'h08, 32'h7);
    rdc(8'h08, 32'h7);
    rdc(8'h10, 32'h0);
    $display("test registers done");
    cmd <= 2'h1;
    step(30);
    rdc(8'h0C, 32'h6);
    chk(pins, 4'hE);
    wb(1'b1, 8'h04, 32'h7);
    wk_pulse();
    chk(pins, 4'h1);
    step(30);
    rdc(8'h0C, 32'h3);
    chk(irq, 1'b1);
    rdc(8'h04, 32'h5);
    wb(1'b1, 8'h04, 32'h5);
    chk(irq, 1'b0);
    rdc(8'h00, 32'h8001);
    step(2);
    rdc(8'h0C, 32'h2);
    step(30);
    chk(pins, 4'hE);
    $display("test sleep done");
    cmd <= 2'h0;
    rxb <= 1'b0;
    wk_pulse();
    rdc(8'h00, 32'h8001);
    step(8);
    chk(pins, 4'hF);
    wk_pulse();
    chk(pins, 4'h1);
    rdc(8'h0C, 32'h3);
    cmd <= 2'h3;
    step(8);
    rdc(8'h0C, 32'h0);
    rdc(8'h00, 32'h6000);
    chk(pins, 4'h9);
    wk_pulse();
    rdc(8'h00, 32'h6000);
    $display("test standby done");
    cmd <= 2'h0;
    step(8);
    chk(pins, 4'hF);
    uv <= 3'h2;
    step(30);
    wk_pulse();
    rdc(8'h00, 32'h8A01);
    wb(1'b1, 8'h04, 32'h7);
    rdc(8'h04, 32'h0);
    step(30);
    rdc(8'h04, 32'h2);
    $display("test undervoltage done");
    cmd <= 2'h2;
    step(8);
    rdc(8'h0C, 32'h1);
    rdc(8'h00, 32'hCA00);
    chk(pins, 4'h9);
    rxb <= 1'b1;
    step(4);
    chk(pins, 4'hF);
    $display("test receive-only done");
    complete_run();
  end
  initial
  begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule // testbench
`default_nettype wire
